// File: logic/record_path_pkg.sv
package record_path_pkg;

	localparam int SAMPLE_W = 24;

	typedef struct packed {
		logic signed [SAMPLE_W-1:0] left;
		logic signed [SAMPLE_W-1:0] right;
	} frame_type;

	typedef struct packed {
		logic write;
		logic read;
		logic [7:0] addr;
		logic [15:0] wdata;
	} reg_req_type;

	// Register indexes on the control port
	localparam logic [7:0] ADDR_VOLUME = 8'h20;
	localparam logic [7:0] ADDR_AMP = 8'h21;
	localparam logic [7:0] ADDR_FILTER = 8'h22;

	// Writable bits; all others are reserved
	localparam logic [15:0] VOLUME_MASK = 16'hffff;
	localparam logic [15:0] AMP_MASK = 16'h8f0f;
	localparam logic [15:0] FILTER_MASK = 16'h1003;

	localparam logic [15:0] VOLUME_RESET = 16'h0000;
	localparam logic [15:0] AMP_RESET = 16'h0000;
	localparam logic [15:0] FILTER_RESET = 16'h0003;

	localparam int LEFT_VOL_LSB = 8;
	localparam int RIGHT_VOL_LSB = 0;
	localparam int MUTE_BIT = 15;
	localparam int LEFT_AMP_LSB = 8;
	localparam int RIGHT_AMP_LSB = 0;
	localparam int POLARITY_BIT = 12;
	localparam int BYPASS_BIT = 1;
	localparam int HIGHPASS_BIT = 0;

	localparam logic signed [7:0] VOL_MAX_CODE = 8'sh30;
	localparam logic [7:0] VOL_SILENT_CODE = 8'h80;
	localparam logic [3:0] AMP_MAX_CODE = 4'h8;
	localparam logic [4:0] AMP_STEP_DB = 5'h03;

	// Half-decibel steps per factor of two, boost exponent at top code
	localparam int STEPS_PER_OCTAVE = 12;
	localparam int MAX_BOOST_SHIFT = 4;
	localparam int FRAC_BITS = 15;

	// Corner settings of the two offset filters
	localparam int DC_SHIFT = 10;
	localparam int HP_SHIFT = 12;

	// Fraction of a factor of two for each half-decibel step, Q15
	function automatic logic [15:0] step_fraction(input logic [3:0] idx);
		case (idx)
			4'h0: step_fraction = 16'h8000;
			4'h1: step_fraction = 16'h78d1;
			4'h2: step_fraction = 16'h7209;
			4'h3: step_fraction = 16'h6ba2;
			4'h4: step_fraction = 16'h6598;
			4'h5: step_fraction = 16'h5fe4;
			4'h6: step_fraction = 16'h5a82;
			4'h7: step_fraction = 16'h556e;
			4'h8: step_fraction = 16'h50a3;
			4'h9: step_fraction = 16'h4c1c;
			4'ha: step_fraction = 16'h47d6;
			default: step_fraction = 16'h43ce;
		endcase
	endfunction

endpackage

// File: logic/sample_fifo.sv
`timescale 1ns/1ps
module sample_fifo #(
	parameter int WIDTH = 48,
	parameter int DEPTH = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CNT_W = $clog2(DEPTH + 1);

	if (DEPTH < 2) begin : g_bad_depth
		$error("sample_fifo needs at least two words");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
	logic [CNT_W-1:0] count, next_count;
	logic next_in_ready, next_out_valid, push, pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem[rd_ptr];

	always_comb begin
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		next_count = count;
		if (push) begin
			next_wr_ptr = (wr_ptr == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
		next_in_ready = next_count != CNT_W'(DEPTH);
		next_out_valid = next_count != '0;
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
			in_ready <= next_in_ready;
			out_valid <= next_out_valid;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

endmodule

// File: logic/record_gain_control.sv
`timescale 1ns/1ps
// Functional notes
// R1 - The left volume code sits in bits 15 to 8 of the volume register and scales left samples.
// R2 - The right volume code sits in bits 7 to 0 and scales right samples on their own.
// R3 - Codes from zero upward add 0.5 dB each, zero is unity and the top valid code is +24 dB.
// R4 - Codes with the top bit set attenuate in 0.5 dB steps down to -63.5 dB, and 80h silences.
// R5 - The mute bit at the top of the amplifier register silences the path while it is one.
// R6 - The left amplifier gain code is held in bits 11 to 8 and drives the left amplifier.
// R7 - The right amplifier gain code is held in bits 3 to 0 and drives the right amplifier.
// R8 - Amplifier codes 0 to 8 select gains from 0 dB to 24 dB in 3 dB steps.
// R9 - Polarity bit 12 of the filter register negates the incoming samples while set.
// R10 - Bit 1 of the filter register bypasses the offset filter when set and enables it when clear.
// R11 - Bit 0 of the filter register enables the sample-rate high-pass when set.
// R12 - The host writes only documented codes; out-of-range codes saturate to the nearest setting.
// R13 - Reserved bits of the three registers read as zero and ignore writes.
module record_gain_control #(
	parameter int FIFO_DEPTH = 16
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire record_path_pkg::reg_req_type reg_req,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire record_path_pkg::frame_type in_frame,
	input wire logic in_valid,
	output logic in_ready,
	output record_path_pkg::frame_type out_frame,
	output logic out_valid,
	input wire logic out_ready,
	output logic [3:0] left_input_amp_gain,
	output logic [3:0] right_input_amp_gain,
	output logic [4:0] left_amp_gain_db,
	output logic [4:0] right_amp_gain_db,
	output logic record_path_mute
);
	import record_path_pkg::*;

	localparam int WIDE_W = SAMPLE_W + 21;
	localparam int ACC_W = SAMPLE_W + HP_SHIFT + 2;
	localparam logic signed [WIDE_W-1:0] POS_LIMIT = WIDE_W'((1 << (SAMPLE_W - 1)) - 1);
	// Most negative sample, one below the negated maximum
	localparam logic signed [WIDE_W-1:0] NEG_LIMIT = ~POS_LIMIT;

	if (FIFO_DEPTH < 2) begin : g_bad_depth
		$error("record_gain_control needs a FIFO of at least two words");
	end

	function automatic logic signed [SAMPLE_W-1:0] saturate(input logic signed [WIDE_W-1:0] v);
		if (v > POS_LIMIT) begin
			saturate = POS_LIMIT[SAMPLE_W-1:0];
		end else if (v < NEG_LIMIT) begin
			saturate = NEG_LIMIT[SAMPLE_W-1:0];
		end else begin
			saturate = v[SAMPLE_W-1:0];
		end
	endfunction

	// One step of a leaky offset tracker: subtract the running mean
	function automatic logic signed [SAMPLE_W-1:0] offset_step(
		input logic signed [SAMPLE_W-1:0] x,
		input logic signed [ACC_W-1:0] acc,
		input int shift
	);
		offset_step = saturate(WIDE_W'(x) - WIDE_W'(acc >>> shift));
	endfunction

	function automatic logic signed [SAMPLE_W-1:0] apply_volume(
		input logic signed [SAMPLE_W-1:0] x,
		input logic [7:0] code
	);
		logic signed [7:0] c;
		logic [7:0] atten;
		logic [3:0] octave;
		logic [3:0] idx;
		logic signed [SAMPLE_W+16:0] prod;
		logic signed [WIDE_W-1:0] scaled;
		c = signed'(code);
		if (c > VOL_MAX_CODE) begin
			c = VOL_MAX_CODE; // [R12]
		end
		atten = 8'(int'(VOL_MAX_CODE) - int'(c)); // [R3] [R4]
		octave = 4'(atten / 8'(STEPS_PER_OCTAVE));
		idx = 4'(atten % 8'(STEPS_PER_OCTAVE));
		prod = x * signed'({1'b0, step_fraction(idx)});
		scaled = WIDE_W'(prod) <<< MAX_BOOST_SHIFT;
		scaled = scaled >>> (FRAC_BITS + int'(octave));
		if (code == VOL_SILENT_CODE) begin
			apply_volume = '0; // [R4]
		end else begin
			apply_volume = saturate(scaled);
		end
	endfunction

	function automatic logic [3:0] clamp_amp(input logic [3:0] code);
		clamp_amp = (code > AMP_MAX_CODE) ? AMP_MAX_CODE : code; // [R12]
	endfunction

	// Register file
	logic [15:0] volume, next_volume;
	logic [15:0] amp, next_amp;
	logic [15:0] filter, next_filter;
	logic [15:0] next_reg_rdata;
	logic next_reg_rvalid;

	always_comb begin
		next_volume = volume;
		next_amp = amp;
		next_filter = filter;
		next_reg_rdata = '0;
		next_reg_rvalid = reg_req.read;
		if (reg_req.write) begin
			if (reg_req.addr == ADDR_VOLUME) begin
				next_volume = reg_req.wdata & VOLUME_MASK;
			end else if (reg_req.addr == ADDR_AMP) begin
				next_amp = reg_req.wdata & AMP_MASK; // [R13]
			end else if (reg_req.addr == ADDR_FILTER) begin
				next_filter = reg_req.wdata & FILTER_MASK; // [R13]
			end
		end
		if (reg_req.read) begin
			if (reg_req.addr == ADDR_VOLUME) begin
				next_reg_rdata = volume;
			end else if (reg_req.addr == ADDR_AMP) begin
				next_reg_rdata = amp;
			end else if (reg_req.addr == ADDR_FILTER) begin
				next_reg_rdata = filter;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			volume <= VOLUME_RESET;
			amp <= AMP_RESET;
			filter <= FILTER_RESET;
			reg_rdata <= '0;
			reg_rvalid <= 1'b0;
		end else begin
			volume <= next_volume;
			amp <= next_amp;
			filter <= next_filter;
			reg_rdata <= next_reg_rdata;
			reg_rvalid <= next_reg_rvalid;
		end
	end

	// Amplifier and mute outputs
	logic [3:0] next_left_amp, next_right_amp;

	always_comb begin
		next_left_amp = clamp_amp(amp[LEFT_AMP_LSB +: 4]); // [R6]
		next_right_amp = clamp_amp(amp[RIGHT_AMP_LSB +: 4]); // [R7]
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			left_input_amp_gain <= '0;
			right_input_amp_gain <= '0;
			left_amp_gain_db <= '0;
			right_amp_gain_db <= '0;
			record_path_mute <= 1'b0;
		end else begin
			left_input_amp_gain <= next_left_amp;
			right_input_amp_gain <= next_right_amp;
			left_amp_gain_db <= 5'(next_left_amp * AMP_STEP_DB); // [R8]
			right_amp_gain_db <= 5'(next_right_amp * AMP_STEP_DB); // [R8]
			record_path_mute <= amp[MUTE_BIT]; // [R5]
		end
	end

	// Sample path
	frame_type fifo_frame, next_out_frame;
	logic fifo_valid, take, next_out_valid;
	logic signed [SAMPLE_W-1:0] ch_in [2];
	logic signed [SAMPLE_W-1:0] ch_out [2];
	logic [7:0] ch_code [2];
	logic signed [ACC_W-1:0] dc_acc [2];
	logic signed [ACC_W-1:0] next_dc_acc [2];
	logic signed [ACC_W-1:0] hp_acc [2];
	logic signed [ACC_W-1:0] next_hp_acc [2];

	sample_fifo #(
		.WIDTH($bits(frame_type)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_data(in_frame),
		.in_valid(in_valid),
		.in_ready(in_ready),
		.out_data(fifo_frame),
		.out_valid(fifo_valid),
		.out_ready(take)
	);

	// A stalled output holds the FIFO, which then fills and refuses input
	assign take = fifo_valid && (!out_valid || out_ready);

	always_comb begin
		logic signed [SAMPLE_W-1:0] s;
		s = '0;
		ch_in[0] = fifo_frame.left;
		ch_in[1] = fifo_frame.right;
		ch_code[0] = volume[LEFT_VOL_LSB +: 8]; // [R1]
		ch_code[1] = volume[RIGHT_VOL_LSB +: 8]; // [R2]
		for (int ch = 0; ch < 2; ch++) begin
			next_dc_acc[ch] = dc_acc[ch];
			next_hp_acc[ch] = hp_acc[ch];
			s = ch_in[ch];
			if (filter[POLARITY_BIT]) begin
				s = saturate(-WIDE_W'(s)); // [R9]
			end
			if (!filter[BYPASS_BIT]) begin
				s = offset_step(s, dc_acc[ch], DC_SHIFT); // [R10]
				next_dc_acc[ch] = dc_acc[ch] + ACC_W'(s);
			end
			if (filter[HIGHPASS_BIT]) begin
				s = offset_step(s, hp_acc[ch], HP_SHIFT); // [R11]
				next_hp_acc[ch] = hp_acc[ch] + ACC_W'(s);
			end
			s = apply_volume(s, ch_code[ch]); // [R1] [R2]
			if (amp[MUTE_BIT]) begin
				s = '0; // [R5]
			end
			ch_out[ch] = s;
		end
		next_out_frame = out_frame;
		next_out_valid = out_valid && !out_ready;
		if (take) begin
			next_out_frame.left = ch_out[0];
			next_out_frame.right = ch_out[1];
			next_out_valid = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			out_frame <= '0;
			out_valid <= 1'b0;
			dc_acc <= '{default: '0};
			hp_acc <= '{default: '0};
		end else begin
			out_frame <= next_out_frame;
			out_valid <= next_out_valid;
			if (take) begin
				dc_acc <= next_dc_acc;
				hp_acc <= next_hp_acc;
			end
		end
	end

	// Checks
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	logic clean_path;
	assign clean_path = filter[BYPASS_BIT] && !filter[HIGHPASS_BIT] && !amp[MUTE_BIT];

	reserved_bits_zero_a: assert property ( // [R13]
		(amp & ~AMP_MASK) == '0 && (filter & ~FILTER_MASK) == '0
	) else $error("reserved register bits are not zero");

	volume_readback_a: assert property ( // [R1]
		reg_req.write && reg_req.addr == ADDR_VOLUME ##1
		reg_req.read && !reg_req.write && reg_req.addr == ADDR_VOLUME
		|=> reg_rdata == $past(reg_req.wdata, 2)
	) else $error("volume register read back differs from write");

	left_amp_follow_a: assert property ( // [R6]
		reg_req.write && reg_req.addr == ADDR_AMP && reg_req.wdata[11:8] <= AMP_MAX_CODE
		|=> ##1 left_input_amp_gain == $past(reg_req.wdata[11:8], 2)
	) else $error("left amplifier gain did not follow register");

	right_amp_clamp_a: assert property ( // [R7]
		reg_req.write && reg_req.addr == ADDR_AMP && reg_req.wdata[3:0] > AMP_MAX_CODE
		|=> ##1 right_input_amp_gain == AMP_MAX_CODE
	) else $error("right amplifier gain not saturated");

	amp_db_map_a: assert property ( // [R8]
		left_amp_gain_db == 5'(left_input_amp_gain * AMP_STEP_DB)
	) else $error("left amplifier decibel value wrong");

	mute_silence_a: assert property ( // [R5]
		take && amp[MUTE_BIT] |=> out_valid && out_frame == '0
	) else $error("muted path produced audio");

	silent_code_a: assert property ( // [R4]
		take && volume[15:8] == VOL_SILENT_CODE |=> out_frame.left == '0
	) else $error("silent volume code passed audio");

	unity_gain_a: assert property ( // [R3]
		take && clean_path && !filter[POLARITY_BIT] && volume[7:0] == '0
		|=> out_frame.right == $past(fifo_frame.right)
	) else $error("zero volume code is not unity");

	polarity_flip_a: assert property ( // [R9]
		take && clean_path && filter[POLARITY_BIT] && volume[15:8] == '0
		&& fifo_frame.left != NEG_LIMIT[SAMPLE_W-1:0]
		|=> out_frame.left == -$past(fifo_frame.left)
	) else $error("polarity inversion not applied");

	mute_take_c: cover property (take && amp[MUTE_BIT]);
	silent_take_c: cover property (take && volume[7:0] == VOL_SILENT_CODE);
	fifo_full_c: cover property (!in_ready ##1 in_ready);
	highpass_take_c: cover property (take && filter[HIGHPASS_BIT] && !filter[BYPASS_BIT]);

endmodule

// File: verification/control_host.sv
`timescale 1ns/1ps
module control_host (
	input wire logic clk,
	output record_path_pkg::reg_req_type reg_req,
	input wire logic [15:0] reg_rdata,
	input wire logic reg_rvalid
);
	import record_path_pkg::*;
	initial reg_req = '0;
	// One strobe cycle, answer sampled a cycle later
	task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d,
			output logic [15:0] q, output logic v);
		@(posedge clk);
		reg_req <= '{write: wr, read: !wr, addr: a, wdata: d};
		@(posedge clk);
		reg_req <= '0;
		#1;
		q = reg_rdata;
		v = reg_rvalid;
	endtask
	// Write then read the same register on the next edge
	task automatic write_read(input logic [7:0] a, input logic [15:0] d,
			output logic [15:0] q);
		@(posedge clk);
		reg_req <= '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		reg_req <= '{write: 1'b0, read: 1'b1, addr: a, wdata: d};
		@(posedge clk);
		reg_req <= '0;
		#1;
		q = reg_rdata;
	endtask
endmodule

// File: verification/adc_decimator_gain_control_tb.sv
`timescale 1ns/1ps
module adc_decimator_gain_control_tb;
	import record_path_pkg::*;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	reg_req_type reg_req;
	logic [15:0] reg_rdata;
	logic reg_rvalid;
	frame_type in_frame = '0;
	logic in_valid = 1'b0;
	logic in_ready;
	frame_type out_frame;
	logic out_valid;
	logic out_ready = 1'b0;
	logic [3:0] left_gain;
	logic [3:0] right_gain;
	logic [4:0] left_db;
	logic [4:0] right_db;
	logic mute;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	int n;
	logic [31:0] rnd = 32'ha641;
	logic [31:0] sink_rnd = 32'ha641;
	logic hold = 1'b0;
	logic track = 1'b1;
	logic [15:0] vol = 16'h0000;
	logic [15:0] amp = 16'h0000;
	logic [15:0] filt = 16'h0003;
	frame_type exp_q[$];
	frame_type ef;
	frame_type last;
	logic [15:0] vols[6] = '{16'h0000, 16'h30e8, 16'h7f80, 16'h80e8, 16'h0000, 16'h0000};
	logic [15:0] amps[6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h8000};
	logic [15:0] filts[6] = '{16'h0002, 16'h0002, 16'h0002, 16'h0002, 16'h1002, 16'h1002};

	always #50 clk = ~clk;

	control_host u_host(.clk(clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid));
	record_gain_control #(.FIFO_DEPTH(16)) u_dut(.clk(clk), .sys_rst(sys_rst),
		.reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.in_frame(in_frame), .in_valid(in_valid), .in_ready(in_ready),
		.out_frame(out_frame), .out_valid(out_valid), .out_ready(out_ready),
		.left_input_amp_gain(left_gain), .right_input_amp_gain(right_gain),
		.left_amp_gain_db(left_db), .right_amp_gain_db(right_db), .record_path_mute(mute));

	function automatic logic [31:0] lfsr_step(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Only codes with exact binary gains are used in the exact tests
	function automatic logic [23:0] scale(input logic signed [23:0] x, input logic [7:0] c);
		logic signed [31:0] v;
		v = x;
		if (filt[12])
			v = -v;
		if (amp[15] || c == 8'h80)
			v = 0;
		else if (c == 8'he8)
			v = v >>> 2;
		else if (c != 8'h00)
			v = v * 16;
		if (v > 32'sh7fffff)
			v = 32'sh7fffff;
		if (v < -32'sh800000)
			v = -32'sh800000;
		return v[23:0];
	endfunction

	function automatic frame_type expect_of(input frame_type f);
		return '{left: scale(f.left, vol[15:8]), right: scale(f.right, vol[7:0])};
	endfunction

	function automatic frame_type rand_frame();
		rnd = lfsr_step(rnd);
		rand_frame.left = {rnd[23:2], 2'b00};
		rnd = lfsr_step(lfsr_step(rnd));
		rand_frame.right = {rnd[31:10], 2'b00};
	endfunction

	task automatic compare_val(input string what, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask

	task automatic compare_frame(input frame_type e, input frame_type g);
		checks++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] frame expected %h seen %h", e, g);
		end
	endtask

	task automatic give_verdict();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		logic [15:0] q;
		logic v;
		u_host.access(1'b1, a, d, q, v);
		@(posedge clk);
	endtask

	task automatic check_reg(input logic [7:0] a, input logic [15:0] e);
		logic [15:0] q;
		logic v;
		u_host.access(1'b0, a, 16'h0000, q, v);
		compare_val("read valid", 16'h0001, {15'h0, v});
		compare_val("read data", e, q);
		@(posedge clk);
	endtask

	task automatic setup(input logic [15:0] v, input logic [15:0] a, input logic [15:0] f);
		wr(ADDR_VOLUME, v);
		wr(ADDR_AMP, a);
		wr(ADDR_FILTER, f);
		vol = v;
		amp = a;
		filt = f;
	endtask

	task automatic send(input frame_type f);
		in_frame <= f;
		in_valid <= 1'b1;
		do
			@(posedge clk);
		while (!in_ready);
		exp_q.push_back(expect_of(f));
	endtask

	task automatic drain();
		in_valid <= 1'b0;
		repeat (400)
			if (exp_q.size() != 0)
				@(posedge clk);
		compare_val("frames left", 16'h0000, 16'(exp_q.size()));
	endtask

	// Sink with random stalls, scoreboard in order
	always @(posedge clk) begin
		sink_rnd = lfsr_step(sink_rnd);
		out_ready <= !hold && sink_rnd[2:0] != 3'h0;
		if (!sys_rst && out_valid && out_ready) begin
			last = out_frame;
			if (exp_q.size() == 0)
				compare_val("spare frame", 16'h0000, 16'h0001);
			else begin
				ef = exp_q.pop_front();
				if (track)
					compare_frame(ef, out_frame);
			end
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			give_verdict();
		end
	end

	initial begin
		frame_type f;
		logic [15:0] q;
		repeat (4) @(posedge clk);
		sys_rst <= 1'b0;
		check_reg(ADDR_VOLUME, 16'h0000);
		check_reg(ADDR_AMP, 16'h0000);
		check_reg(ADDR_FILTER, 16'h0003);
		check_reg(8'h23, 16'h0000);
		wr(ADDR_AMP, 16'hffff);
		check_reg(ADDR_AMP, 16'h8f0f);
		compare_val("mute", 16'h0001, {15'h0, mute});
		compare_val("left amp", 16'h0008, {12'h0, left_gain});
		wr(ADDR_FILTER, 16'hffff);
		check_reg(ADDR_FILTER, 16'h1003);
		wr(ADDR_VOLUME, 16'h8123);
		check_reg(ADDR_VOLUME, 16'h8123);
		u_host.write_read(ADDR_VOLUME, 16'h5a7f, q);
		compare_val("volume back to back", 16'h5a7f, q);
		@(posedge clk);
		for (int c = 0; c <= 8; c++) begin
			wr(ADDR_AMP, {4'h0, 4'(c), 4'h0, 4'(8 - c)});
			@(negedge clk);
			compare_val("amps", 16'(c * 256 + 8 - c), {4'h0, left_gain, 4'h0, right_gain});
			compare_val("amp db", {8'(3 * c), 8'(24 - 3 * c)}, {3'h0, left_db, 3'h0, right_db});
		end
		for (int i = 0; i < 6; i++) begin
			setup(vols[i], amps[i], filts[i]);
			compare_val("mute", {15'h0, amps[i][15]}, {15'h0, mute});
			repeat (40)
				send(rand_frame());
			drain();
		end
		// Stall the sink until the buffer refuses, then drain in order
		hold <= 1'b1;
		n = 0;
		f = rand_frame();
		repeat (24) begin
			in_frame <= f;
			in_valid <= 1'b1;
			@(posedge clk);
			if (in_ready) begin
				n++;
				exp_q.push_back(expect_of(f));
				f = rand_frame();
			end
		end
		compare_val("fill count", 16'h0001, {15'h0, n >= 16 && n <= 19});
		compare_val("ready when full", 16'h0000, {15'h0, in_ready});
		hold <= 1'b0;
		drain();
		// Constant offset must decay with either filter on
		track <= 1'b0;
		for (int k = 0; k < 2; k++) begin
			setup(16'h0000, 16'h0000, k ? 16'h0003 : 16'h0000);
			repeat (9000)
				send('{left: 24'h100000, right: 24'h100000});
			drain();
			compare_val("decay", 16'h0001,
				{15'h0, !last.left[23] && last.left < 24'sh040000});
		end
		give_verdict();
	end
endmodule
